// >>> psu_control_status_logic.sv
`timescale 1ns/1ns
`default_nettype none
module psu_control_status_logic #(
   parameter int unsigned DEBOUNCE_CYCLES = psu_ctrl_pkg::DEBOUNCE_CYCLES,
   parameter int unsigned STARTUP_CYCLES = psu_ctrl_pkg::STARTUP_CYCLES,
   parameter int unsigned BLINK_CYCLES = psu_ctrl_pkg::BLINK_CYCLES,
   parameter int unsigned FAST_BLINK_CYCLES = psu_ctrl_pkg::FAST_BLINK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic output_enable_n,
   input wire logic inhibit_n,
   input wire logic geo_addr_bit0_n,
   input wire logic geo_addr_bit1_n,
   input wire logic geo_addr_bit2_n,
   input wire logic geo_addr_bit3_n,
   input wire logic geo_addr_bit4_n,
   input wire logic geo_addr_parity_n,
   input wire logic vin_in_range,
   input wire logic outputs_good,
   input wire logic fault_detected,
   input wire logic sw_priority,
   input wire logic sw_outputs_on,
   input wire logic safety_override,
   output logic main_12v_output,
   output logic main_5v_output,
   output logic aux_neg12v_output,
   output logic aux_3v3_output,
   output logic aux_pos12v_output,
   output logic [6:0] i2c_addr,
   output logic addr_parity_ok,
   output logic led_green,
   output logic led_red,
   output logic fail_n,
   output logic system_reset_out_n
);
   typedef enum logic [2:0] {
      ST_WAIT_VIN, ST_STARTUP, ST_READY, ST_FAULT
   } run_state_e;

   logic en_db, inh_db;

   // Pull-ups are modelled by reset value high in the filters
   debounce_filter #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b1)) u_en_db (
      .clk_sys(clk_sys),
      .reset(reset),
      .raw_in(output_enable_n),
      .clean_out(en_db)
   );
   debounce_filter #(.CYCLES(DEBOUNCE_CYCLES), .INIT(1'b1)) u_inh_db (
      .clk_sys(clk_sys),
      .reset(reset),
      .raw_in(inhibit_n),
      .clean_out(inh_db)
   );

   // Geo address synchroniser (pins idle high)
   logic [5:0] geo_s1_q, geo_s2_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         geo_s1_q <= 6'h3F;
         geo_s2_q <= 6'h3F;
      end else begin
         geo_s1_q <= {geo_addr_parity_n, geo_addr_bit4_n, geo_addr_bit3_n,
                      geo_addr_bit2_n, geo_addr_bit1_n, geo_addr_bit0_n};
         geo_s2_q <= geo_s1_q;
      end
   end

   // Count of grounded pins must be odd
   function automatic logic parity_good(input logic [5:0] pins_n);
      parity_good = ^(~pins_n);
   endfunction : parity_good

   // Address latch: once, a debounce time after reset release
   logic [31:0] addr_cnt_q, addr_cnt_d;
   logic addr_done_q, addr_done_d;
   logic [6:0] addr_q, addr_d;
   logic par_ok_q, par_ok_d;
   always_comb begin
      addr_cnt_d = addr_cnt_q;
      addr_done_d = addr_done_q;
      addr_d = addr_q;
      par_ok_d = par_ok_q;
      if (!addr_done_q) begin
         if (addr_cnt_q >= DEBOUNCE_CYCLES - 1) begin
            addr_done_d = 1'b1;
            par_ok_d = parity_good(geo_s2_q);
            if (parity_good(geo_s2_q)) begin
               addr_d = psu_ctrl_pkg::I2C_BASE_ADDR
                        | {2'b00, ~geo_s2_q[4:0]};
            end else begin
               addr_d = psu_ctrl_pkg::I2C_BASE_ADDR;
            end
         end else begin
            addr_cnt_d = addr_cnt_q + 32'h1;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         addr_cnt_q <= '0;
         addr_done_q <= 1'b0;
         addr_q <= psu_ctrl_pkg::I2C_BASE_ADDR;
         par_ok_q <= 1'b0;
      end else begin
         addr_cnt_q <= addr_cnt_d;
         addr_done_q <= addr_done_d;
         addr_q <= addr_d;
         par_ok_q <= par_ok_d;
      end
   end

   // Output decode from control pins or software
   logic main_on_d, aux3_on_d;
   logic main_on_q, aux3_on_q;
   always_comb begin
      main_on_d = 1'b0;
      aux3_on_d = 1'b0;
      if (sw_priority != psu_ctrl_pkg::SW_PRIO_RESET) begin
         main_on_d = sw_outputs_on;
         aux3_on_d = sw_outputs_on;
      end else begin
         unique case ({en_db, inh_db})
            2'b11: begin
               main_on_d = 1'b0;
               aux3_on_d = 1'b0;
            end
            2'b01: begin
               main_on_d = 1'b1;
               aux3_on_d = 1'b1;
            end
            2'b10: begin
               main_on_d = 1'b0;
               aux3_on_d = 1'b0;
            end
            2'b00: begin
               main_on_d = 1'b0;
               aux3_on_d = 1'b1;
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         main_on_q <= 1'b0;
         aux3_on_q <= 1'b0;
      end else begin
         main_on_q <= main_on_d;
         aux3_on_q <= aux3_on_d;
      end
   end

   // Run state and start-up timer
   run_state_e st_q, st_d;
   logic [31:0] st_cnt_q, st_cnt_d;
   always_comb begin
      st_d = st_q;
      st_cnt_d = st_cnt_q;
      unique case (st_q)
         ST_WAIT_VIN: begin
            st_cnt_d = '0;
            if (vin_in_range) begin
               st_d = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (!vin_in_range) begin
               st_d = ST_WAIT_VIN;
            end else if (st_cnt_q >= STARTUP_CYCLES - 1) begin
               st_d = ST_READY;
            end else begin
               st_cnt_d = st_cnt_q + 32'h1;
            end
         end
         ST_READY: begin
            if (fault_detected) begin
               st_d = ST_FAULT;
            end else if (!vin_in_range) begin
               st_d = ST_WAIT_VIN;
            end
         end
         ST_FAULT: begin
            if (!vin_in_range) begin
               st_d = ST_WAIT_VIN;
            end
         end
         default: st_d = ST_WAIT_VIN;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= ST_WAIT_VIN;
         st_cnt_q <= '0;
      end else begin
         st_q <= st_d;
         st_cnt_q <= st_cnt_d;
      end
   end

   // Blink phase generators
   logic [31:0] slow_cnt_q, slow_cnt_d, fast_cnt_q, fast_cnt_d;
   logic slow_ph_q, slow_ph_d, fast_ph_q, fast_ph_d;
   always_comb begin
      slow_cnt_d = slow_cnt_q + 32'h1;
      slow_ph_d = slow_ph_q;
      fast_cnt_d = fast_cnt_q + 32'h1;
      fast_ph_d = fast_ph_q;
      if (slow_cnt_q >= BLINK_CYCLES - 1) begin
         slow_cnt_d = '0;
         slow_ph_d = ~slow_ph_q;
      end
      if (fast_cnt_q >= FAST_BLINK_CYCLES - 1) begin
         fast_cnt_d = '0;
         fast_ph_d = ~fast_ph_q;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         slow_cnt_q <= '0;
         fast_cnt_q <= '0;
         slow_ph_q <= 1'b0;
         fast_ph_q <= 1'b0;
      end else begin
         slow_cnt_q <= slow_cnt_d;
         fast_cnt_q <= fast_cnt_d;
         slow_ph_q <= slow_ph_d;
         fast_ph_q <= fast_ph_d;
      end
   end

   // Indicator with fail and system reset: both set in ready, only system reset set in fault
   logic grn_d, red_d, fail_d, srst_d;
   logic grn_q, red_q, fail_q, srst_q;
   always_comb begin
      grn_d = 1'b0;
      red_d = 1'b0;
      fail_d = 1'b0;
      srst_d = 1'b0;
      unique case (st_q)
         ST_WAIT_VIN: begin
            grn_d = 1'b0;
         end
         ST_STARTUP: begin
            red_d = 1'b1;
         end
         ST_FAULT: begin
            red_d = slow_ph_q;
            srst_d = 1'b1;
         end
         ST_READY: begin
            fail_d = 1'b1;
            srst_d = 1'b1;
            if (safety_override) begin
               grn_d = slow_ph_q;
               red_d = ~slow_ph_q;
            end else if (sw_priority) begin
               grn_d = fast_ph_q;
            end else if (outputs_good && !en_db) begin
               grn_d = 1'b1;
            end else begin
               grn_d = slow_ph_q;
            end
         end
         default: grn_d = 1'b0;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         grn_q <= 1'b0;
         red_q <= 1'b0;
         fail_q <= 1'b0;
         srst_q <= 1'b0;
      end else begin
         grn_q <= grn_d;
         red_q <= red_d;
         fail_q <= fail_d;
         srst_q <= srst_d;
      end
   end

   assign main_12v_output = main_on_q;
   assign main_5v_output = main_on_q;
   assign aux_neg12v_output = main_on_q;
   assign aux_pos12v_output = main_on_q;
   assign aux_3v3_output = aux3_on_q;
   assign i2c_addr = addr_q;
   assign addr_parity_ok = par_ok_q;
   assign led_green = grn_q;
   assign led_red = red_q;
   assign fail_n = fail_q;
   assign system_reset_out_n = srst_q;

   // Checks
   output_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sw_priority == 1'b0 && en_db && inh_db) |=> !main_12v_output && !aux_3v3_output)
      else $error("outputs not off with enable high");
   all_on_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sw_priority == 1'b0 && !en_db && inh_db) |=> main_5v_output && aux_3v3_output)
      else $error("outputs not on with enable low");
   aux_only_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sw_priority == 1'b0 && !en_db && !inh_db) |=> aux_3v3_output && !main_12v_output)
      else $error("only 3v3 aux expected");
   inhibit_off_a: assert property (@(posedge clk_sys) disable iff (reset)
      (sw_priority == 1'b0 && en_db && !inh_db) |=> !aux_3v3_output && !aux_pos12v_output)
      else $error("inhibit should switch outputs off");
   debounce_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
      $changed(en_db) |-> $past(output_enable_n, 3) == en_db)
      else $error("enable accepted without stable input");
   addr_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
      addr_done_q |=> $stable(i2c_addr))
      else $error("address changed after latch");
   addr_base_a: assert property (@(posedge clk_sys) disable iff (reset)
      (addr_done_q && !addr_parity_ok) |-> i2c_addr == psu_ctrl_pkg::I2C_BASE_ADDR)
      else $error("bad parity must use base address");
   startup_red_a: assert property (@(posedge clk_sys) disable iff (reset)
      (st_q == ST_STARTUP) |=> (st_q != ST_STARTUP) || (led_red && !fail_n && !system_reset_out_n))
      else $error("start-up indication wrong");
   fault_ind_a: assert property (@(posedge clk_sys) disable iff (reset)
      (st_q == ST_FAULT) |=> (st_q != ST_FAULT) || (!fail_n && system_reset_out_n && !led_green))
      else $error("fault indication wrong");
   ready_srst_a: assert property (@(posedge clk_sys) disable iff (reset)
      (st_q == ST_READY) |=> (st_q != ST_READY) || (fail_n && system_reset_out_n))
      else $error("ready outputs wrong");
   cover_ready_c: cover property (@(posedge clk_sys) st_q == ST_READY);
   cover_fault_c: cover property (@(posedge clk_sys) st_q == ST_FAULT);
   cover_aux_c: cover property (@(posedge clk_sys) aux_3v3_output && !main_12v_output);
   cover_addr_c: cover property (@(posedge clk_sys) addr_done_q && addr_parity_ok);
endmodule : psu_control_status_logic
`default_nettype wire

// >>> psu_ctrl_pkg.sv
package psu_ctrl_pkg;
   // System clock
   localparam int unsigned CLK_MHZ = 250;
   // Debounce: least 3 ms, typical 5 ms
   localparam int unsigned DEBOUNCE_MS = 5;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000 * CLK_MHZ;
   // Start-up steady red window
   localparam int unsigned STARTUP_MS = 100;
   localparam int unsigned STARTUP_CYCLES = STARTUP_MS * 1000 * CLK_MHZ;
   // Indicator blink half periods
   localparam int unsigned BLINK_MS = 250;
   localparam int unsigned BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
   localparam int unsigned FAST_BLINK_MS = 62;
   localparam int unsigned FAST_BLINK_CYCLES = FAST_BLINK_MS * 1000 * CLK_MHZ;
   // Address
   localparam logic [6:0] I2C_BASE_ADDR = 7'h20;
   localparam int unsigned GEO_BITS = 5;
   // Software-priority bit position in the status register
   localparam int unsigned SW_PRIO_BIT = 4;
   localparam logic SW_PRIO_RESET = 1'b0;
   localparam logic [7:0] STATUS_CMD_CODE = 8'h55;
   // Indicator colours
   typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_RED} led_colour_e;
endpackage : psu_ctrl_pkg

// >>> debounce_filter.sv
`timescale 1ns/1ns
`default_nettype none
module debounce_filter #(
   parameter int unsigned CYCLES = 16,
   parameter logic INIT = 1'b1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic raw_in,
   output logic clean_out
);
   logic [1:0] sync_q;
   logic [31:0] cnt_q, cnt_d;
   logic clean_q, clean_d;

   // Restart the count whenever input equals the accepted level
   always_comb begin
      cnt_d = cnt_q;
      clean_d = clean_q;
      if (sync_q[1] == clean_q) begin
         cnt_d = '0;
      end else if (cnt_q >= CYCLES - 1) begin
         cnt_d = '0;
         clean_d = sync_q[1];
      end else begin
         cnt_d = cnt_q + 32'h1;
      end
   end

   // Two-stage synchroniser then filter state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_q <= {INIT, INIT};
         cnt_q <= '0;
         clean_q <= INIT;
      end else begin
         sync_q <= {sync_q[0], raw_in};
         cnt_q <= cnt_d;
         clean_q <= clean_d;
      end
   end
   assign clean_out = clean_q;
endmodule : debounce_filter
`default_nettype wire

// >>> backplane_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Backplane controller: grounds control and address pins or releases them
module backplane_ctrl_model (
   input wire logic en_gnd,
   input wire logic inh_gnd,
   input wire logic [4:0] geo_gnd,
   input wire logic par_break,
   output logic output_enable_n,
   output logic inhibit_n,
   output logic [4:0] geo_n,
   output logic geo_addr_parity_n
);
   logic par_gnd;
   // Released lines sit at the pull-up level
   assign output_enable_n = ~en_gnd;
   assign inhibit_n = ~inh_gnd;
   assign geo_n = ~geo_gnd;
   // Parity strap keeps the grounded count odd unless told to break it
   assign par_gnd = ~(^geo_gnd) ^ par_break;
   assign geo_addr_parity_n = ~par_gnd;
endmodule : backplane_ctrl_model
`default_nettype wire

// >>> psu_control_status_logic_tb.sv
`timescale 1ns/1ns
`default_nettype none
module psu_control_status_logic_tb;
   localparam int unsigned DEB = 8;
   localparam int unsigned STU = 20;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic en_gnd = 1'b0, inh_gnd = 1'b0, par_break = 1'b0;
   logic [4:0] geo_gnd = 5'h00;
   logic vin_in_range = 1'b0, outputs_good = 1'b0, fault_detected = 1'b0;
   logic sw_priority = 1'b0, sw_outputs_on = 1'b0, safety_override = 1'b0;
   logic output_enable_n, inhibit_n, geo_addr_parity_n;
   logic [4:0] geo_n;
   logic main_12v_output, main_5v_output, aux_neg12v_output;
   logic aux_3v3_output, aux_pos12v_output, addr_parity_ok;
   logic led_green, led_red, fail_n, system_reset_out_n;
   logic [6:0] i2c_addr;
   logic [4:0] outs;
   int err_total = 0;
   int checks = 0;
   int gt, rt;
   bit gon, ron, alt;
   logic [4:0] tt_out [4] = '{5'h00, 5'h00, 5'h01, 5'h1F};
   logic [1:0] tt_pin [4] = '{2'b00, 2'b10, 2'b11, 2'b01};

   assign outs = {main_12v_output, main_5v_output, aux_neg12v_output,
      aux_pos12v_output, aux_3v3_output};

   // Clock at 250 MHz
   always #2 clk_sys = ~clk_sys;

   backplane_ctrl_model far_u (.en_gnd(en_gnd), .inh_gnd(inh_gnd), .geo_gnd(geo_gnd),
      .par_break(par_break), .output_enable_n(output_enable_n), .inhibit_n(inhibit_n),
      .geo_n(geo_n), .geo_addr_parity_n(geo_addr_parity_n));

   psu_control_status_logic #(.DEBOUNCE_CYCLES(DEB), .STARTUP_CYCLES(STU),
      .BLINK_CYCLES(4), .FAST_BLINK_CYCLES(2)) dut_u (
      .clk_sys(clk_sys), .reset(reset), .output_enable_n(output_enable_n),
      .inhibit_n(inhibit_n), .geo_addr_bit0_n(geo_n[0]), .geo_addr_bit1_n(geo_n[1]),
      .geo_addr_bit2_n(geo_n[2]), .geo_addr_bit3_n(geo_n[3]),
      .geo_addr_bit4_n(geo_n[4]), .geo_addr_parity_n(geo_addr_parity_n),
      .vin_in_range(vin_in_range), .outputs_good(outputs_good),
      .fault_detected(fault_detected), .sw_priority(sw_priority),
      .sw_outputs_on(sw_outputs_on), .safety_override(safety_override),
      .main_12v_output(main_12v_output), .main_5v_output(main_5v_output),
      .aux_neg12v_output(aux_neg12v_output), .aux_3v3_output(aux_3v3_output),
      .aux_pos12v_output(aux_pos12v_output), .i2c_addr(i2c_addr),
      .addr_parity_ok(addr_parity_ok), .led_green(led_green), .led_red(led_red),
      .fail_n(fail_n), .system_reset_out_n(system_reset_out_n));

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   task automatic chk(input bit ok, input string msg);
      checks++;
      if (!ok) begin
         err_total++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // Count indicator toggles and flag whether each lights over a window
   task automatic watch(input int n);
      logic pg;
      logic pr;
      gt = 0;
      rt = 0;
      gon = 0;
      ron = 0;
      alt = 1;
      pg = led_green;
      pr = led_red;
      repeat (n) begin
         tick(1);
         if (led_green !== pg) gt++;
         if (led_red !== pr) rt++;
         if (led_green === 1'b1) gon = 1;
         if (led_red === 1'b1) ron = 1;
         if (led_green === led_red) alt = 0;
         pg = led_green;
         pr = led_red;
      end
   endtask : watch

   // Bounded wait: 0 for released system reset, 1 for all outputs on
   task automatic wait_for(input int code, input int lim);
      for (int k = 0; k < lim; k++) begin
         tick(1);
         if (code == 0 && system_reset_out_n === 1'b1) return;
         if (code == 1 && outs === 5'h1F) return;
      end
      chk(0, "wait limit reached");
      test_done();
   endtask : wait_for

   task automatic strap_reset(input logic [4:0] g, input logic brk);
      @(posedge clk_sys);
      geo_gnd <= g;
      par_break <= brk;
      reset <= 1'b1;
      tick(16);
      @(posedge clk_sys);
      reset <= 1'b0;
      tick(DEB + 8);
   endtask : strap_reset

   // Strap patterns per power cycle and the address each must give
   logic [4:0] g [3] = '{5'h15, 5'h00, 5'h0A};
   logic [6:0] a [3] = '{7'h35, 7'h20, 7'h20};

   initial begin
      // Address latch per power cycle, then pin changes ignored
      for (int i = 0; i < 3; i++) begin
         strap_reset(g[i], i == 2);
         chk(i2c_addr === a[i], "address");
         chk(addr_parity_ok === (i != 2), "parity flag");
         chk({led_green, led_red, fail_n, system_reset_out_n} === 4'h0, "idle ind");
         @(posedge clk_sys);
         geo_gnd <= ~g[i];
         tick(DEB + 8);
         chk(i2c_addr === a[i], "address moved");
      end
      // Start-up: steady red with fail and reset low, then blinking green
      @(posedge clk_sys);
      vin_in_range <= 1'b1;
      tick(3);
      watch(STU - 6);
      chk(rt == 0 && ron && !gon, "startup red");
      chk(fail_n === 1'b0 && system_reset_out_n === 1'b0, "startup lines");
      wait_for(0, 12);
      watch(24);
      chk(gt >= 4 && !ron, "ready blink green");
      // Enable grounded: no change before the debounce delay
      @(posedge clk_sys);
      outputs_good <= 1'b1;
      en_gnd <= 1'b1;
      tick(DEB + 2);
      chk(outs === 5'h00, "early accept");
      wait_for(1, DEB + 10);
      watch(16);
      chk(gt == 0 && gon && !ron, "steady green");
      chk(fail_n === 1'b1 && system_reset_out_n === 1'b1, "good lines");
      // Short release glitch is filtered
      @(posedge clk_sys);
      en_gnd <= 1'b0;
      tick(4);
      @(posedge clk_sys);
      en_gnd <= 1'b1;
      for (int k = 0; k < DEB + 8; k++) begin
         tick(1);
         chk(outs === 5'h1F, "glitch passed");
      end
      // Pin decode table
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         {inh_gnd, en_gnd} <= tt_pin[i];
         tick(DEB + 8);
         chk(outs === tt_out[i], "pin decode");
      end
      // Software priority overrides pins and blinks fast
      @(posedge clk_sys);
      {inh_gnd, en_gnd} <= 2'b00;
      sw_priority <= 1'b1;
      sw_outputs_on <= 1'b1;
      tick(DEB + 8);
      chk(outs === 5'h1F, "sw on");
      watch(16);
      chk(gt >= 6 && !ron, "fast green");
      @(posedge clk_sys);
      sw_outputs_on <= 1'b0;
      tick(4);
      chk(outs === 5'h00, "sw off");
      @(posedge clk_sys);
      safety_override <= 1'b1;
      tick(4);
      watch(24);
      chk(alt && gt >= 4 && rt >= 4, "alternate");
      // Fault in operation: blinking red, fail low, reset high
      @(posedge clk_sys);
      safety_override <= 1'b0;
      sw_priority <= 1'b0;
      fault_detected <= 1'b1;
      tick(4);
      watch(24);
      chk(rt >= 4 && !gon, "fault red");
      chk(fail_n === 1'b0 && system_reset_out_n === 1'b1, "fault lines");
      @(posedge clk_sys);
      vin_in_range <= 1'b0;
      tick(4);
      chk({led_green, led_red, fail_n, system_reset_out_n} === 4'h0, "vin lost");
      test_done();
   end
endmodule : psu_control_status_logic_tb
`default_nettype wire
